// ### awg_accum.sv
// phase accumulator with software load and carry output
`timescale 1ns/10ps
module awg_accum
    import awg_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // control
    input  wire logic        run,
    input  wire logic [31:0] incr,
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    // state
    output logic      [31:0] acc_ff,
    output logic             carry_ff
);

    logic [32:0] nxt_sum;

    // 33-bit sum so the wrap past the maximum is visible as bit 32
    assign nxt_sum = {1'b0, acc_ff} + {1'b0, incr};

    // ------------------------------------------------------------------
    // accumulator: a software load overrides the add that cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= AWG_RST_VAL;
        end else if (load) begin
            acc_ff <= load_val;
        end else if (run) begin
            acc_ff <= nxt_sum[31:0];
        end
    end

    // carry flag high exactly in cycles whose add wrapped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            carry_ff <= 1'b0;
        end else begin
            carry_ff <= run && !load && nxt_sum[32];
        end
    end

    a_acc_adds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && !load |=> acc_ff == 32'($past(acc_ff) + $past(incr)))
        else $error("accumulator did not add increment");

    a_carry_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && !load |=> carry_ff == ($past(acc_ff) > acc_ff))
        else $error("carry does not match wrap");

endmodule : awg_accum

// ### awg_pin_load.sv
// pin load model: pads with pull-downs behind the generator outputs
`timescale 1ns/10ps
module awg_pin_load (
    // generator side
    input  wire logic first_pin,
    input  wire logic first_pin_oe,
    input  wire logic second_pin,
    input  wire logic second_pin_oe,
    // pad side
    output logic      pad_a,
    output logic      pad_b
);
    // --------------------------------------------------------------
    // pads
    // --------------------------------------------------------------
    // an undriven pad sits at the pull-down level, never the last value
    assign pad_a = first_pin_oe ? first_pin : 1'b0;
    assign pad_b = second_pin_oe ? second_pin : 1'b0;
endmodule : awg_pin_load

// ### awg_pkg.sv
// package: constants for the accumulator waveform generator
package awg_pkg;

    // ------------------------------------------------------------------
    // register map (word offsets are byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] AWG_CTRL_OFS  = 8'h00;
    localparam logic [7:0] AWG_INCR_OFS  = 8'h04;
    localparam logic [7:0] AWG_ACC_OFS   = 8'h08;
    localparam logic [7:0] AWG_DIR_OFS   = 8'h0c;

    // ------------------------------------------------------------------
    // control word field positions
    // ------------------------------------------------------------------
    localparam int AWG_MODE_LSB  = 26;
    localparam int AWG_TAP_LSB   = 23;
    localparam logic [31:0] AWG_CTRL_MASK = 32'hff80_0000;
    localparam logic [31:0] AWG_RST_VAL   = 32'h0000_0000;
    localparam logic [1:0]  AWG_DIR_RST   = 2'h0;

    // ------------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------------
    localparam logic [4:0] AWG_MODE_VIDEO   = 5'h01;
    localparam logic [4:0] AWG_MODE_PLL_SE  = 5'h02;
    localparam logic [4:0] AWG_MODE_PLL_DF  = 5'h03;
    localparam logic [4:0] AWG_MODE_NCO_SE  = 5'h04;
    localparam logic [4:0] AWG_MODE_NCO_DF  = 5'h05;
    localparam logic [4:0] AWG_MODE_DUTY_SE = 5'h06;
    localparam logic [4:0] AWG_MODE_DUTY_DF = 5'h07;

    // ------------------------------------------------------------------
    // pll model: vco runs at 16x input, taps divide vco by 128 down to 1
    // ------------------------------------------------------------------
    localparam int         AWG_PLL_MULT    = 16;
    localparam int         AWG_VCO_BITS    = 8;
    localparam logic [7:0] AWG_VCO_STEP    = 8'(2 * AWG_PLL_MULT);   // half periods

    typedef enum logic [1:0] {
        AWG_GRP_OFF,
        AWG_GRP_PLL,
        AWG_GRP_NCO,
        AWG_GRP_DUTY
    } awg_grp_t;

    // mode code to mode group
    function automatic awg_grp_t awg_group(input logic [4:0] mode);
        if (mode == AWG_MODE_PLL_SE || mode == AWG_MODE_PLL_DF) begin
            return AWG_GRP_PLL;
        end else if (mode == AWG_MODE_NCO_SE || mode == AWG_MODE_NCO_DF) begin
            return AWG_GRP_NCO;
        end else if (mode == AWG_MODE_DUTY_SE || mode == AWG_MODE_DUTY_DF) begin
            return AWG_GRP_DUTY;
        end else begin
            return AWG_GRP_OFF;
        end
    endfunction : awg_group

endpackage : awg_pkg

// ### awg_pll.sv
// behavioural x16 pll model with eight divided taps
`timescale 1ns/10ps
module awg_pll
    import awg_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // reference and tap
    input  wire logic       enable,
    input  wire logic       ref_in,
    input  wire logic [2:0] tap,
    // output
    output logic            pll_out_ff
);

    // the vco phase advances 32 half periods per reference cycle; bit 0 is
    // the vco itself, higher bits are the divided taps. digital model only:
    // it cannot step faster than clk_sys, so real taps above fsys/2 alias.
    logic [AWG_VCO_BITS+6:0] vco_ff;
    logic [15:0]             per_cnt_ff;
    logic [15:0]             per_ff;
    logic [15:0]             sub_ff;
    logic                    ref_d_ff;
    logic                    rise;

    assign rise = ref_in && !ref_d_ff;

    // reference edge detect and period measurement
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_d_ff   <= 1'b0;
            per_cnt_ff <= 16'h0000;
            per_ff     <= 16'h0001;
        end else begin
            ref_d_ff <= ref_in;
            if (rise) begin
                per_cnt_ff <= 16'h0001;
                per_ff     <= (per_cnt_ff == 16'h0000) ? 16'h0001 : per_cnt_ff;
            end else if (per_cnt_ff != 16'hffff) begin
                per_cnt_ff <= per_cnt_ff + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // phase generator: 16 vco cycles per reference, relocked on each edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vco_ff <= '0;
            sub_ff <= 16'h0000;
        end else if (!enable) begin
            vco_ff <= '0;
            sub_ff <= 16'h0000;
        end else if (rise) begin
            // relock to a whole reference period; clearing the phase here
            // would stop the upper bits counting and kill the slow taps
            vco_ff <= {vco_ff[14:5] + 10'(vco_ff[4]), 5'h00};
            sub_ff <= 16'h0000;
        end else if (sub_ff + {8'h00, AWG_VCO_STEP} >= per_ff) begin
            sub_ff <= 16'(sub_ff + {8'h00, AWG_VCO_STEP} - per_ff);
            vco_ff <= vco_ff + 1'b1;
        end else begin
            sub_ff <= 16'(sub_ff + {8'h00, AWG_VCO_STEP});
        end
    end

    // tap 7 = vco, tap 0 = vco/128
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_out_ff <= 1'b0;
        end else begin
            pll_out_ff <= enable && vco_ff[3'd7 - tap];
        end
    end

endmodule : awg_pll

// ### awg_top.sv
// accumulator waveform generator: registers, mode decode, pin drive
`timescale 1ns/10ps

// Contract
// - oscillator modes add increment every cycle
// - first pin msb; differential adds inverted second
// - quarter increment gives 0,0,1,1 msb
// - frequency is increment over 2^32 times clock
// - above half scale frequency falls again
// - non power-of-two jitter left uncorrected
// - codes 2,3 are pll oscillator modes
// - code 1 video pll outside scope
// - pll multiplies by 16, eight taps
// - tap 0 divides vco by 128, 7 by one
// - tap field used only in pll modes
// - codes 6,7 are duty modes
// - duty output is addition carry
// - increment one carries once per 2^32
// - duty fraction equals increment over 2^32
// - duty equals oscillator only at half scale
module awg_top
    import awg_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // pins
    output logic             first_pin,
    output logic             first_pin_oe,
    output logic             second_pin,
    output logic             second_pin_oe
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] incr_ff;
    logic [1:0]  dir_ff;
    logic [31:0] rdata_ff;
    logic [31:0] acc;
    logic        carry;
    logic        pll_out;
    logic [4:0]  counter_mode_select;
    logic [2:0]  pll_tap_select;
    awg_grp_t    grp;
    logic        diff;
    logic        run;
    logic        acc_load;
    logic        nxt_first;
    logic        nxt_second;
    logic        first_ff;
    logic        second_ff;

    assign counter_mode_select = ctrl_ff[AWG_MODE_LSB +: 5];
    assign pll_tap_select      = ctrl_ff[AWG_TAP_LSB +: 3];
    assign grp                 = awg_group(counter_mode_select);
    assign diff                = counter_mode_select[0];
    // video pll mode is not modelled: it leaves the accumulator idle
    assign run                 = (grp != AWG_GRP_OFF);
    assign acc_load            = reg_wr && (reg_addr == AWG_ACC_OFS);

    // control, increment and direction writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= AWG_RST_VAL;
            incr_ff <= AWG_RST_VAL;
            dir_ff  <= AWG_DIR_RST;
        end else if (reg_wr) begin
            if (reg_addr == AWG_CTRL_OFS) begin
                ctrl_ff <= reg_wdata & AWG_CTRL_MASK;
            end else if (reg_addr == AWG_INCR_OFS) begin
                incr_ff <= reg_wdata;
            end else if (reg_addr == AWG_DIR_OFS) begin
                dir_ff <= reg_wdata[1:0];
            end
        end
    end

    // read data: one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == AWG_CTRL_OFS) begin
                rdata_ff <= ctrl_ff;
            end else if (reg_addr == AWG_INCR_OFS) begin
                rdata_ff <= incr_ff;
            end else if (reg_addr == AWG_ACC_OFS) begin
                rdata_ff <= acc;
            end else if (reg_addr == AWG_DIR_OFS) begin
                rdata_ff <= {30'h0, dir_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    // a write to the accumulator lets software do pwm by loading -width
    awg_accum u_accum (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .run      (run),
        .incr     (incr_ff),
        .load     (acc_load),
        .load_val (reg_wdata),
        .acc_ff   (acc),
        .carry_ff (carry)
    );

    awg_pll u_pll (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .enable     (grp == AWG_GRP_PLL),
        .ref_in     (acc[31]),
        .tap        (pll_tap_select),
        .pll_out_ff (pll_out)
    );

    // ------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------
    // raw msb is passed straight out: the modular wrap gives the falling
    // frequency above half scale and jitter is deliberately not filtered
    always_comb begin
        nxt_first  = 1'b0;
        nxt_second = 1'b0;
        case (grp)
            AWG_GRP_NCO: begin
                nxt_first  = acc[31];
                nxt_second = diff && !acc[31];
            end
            AWG_GRP_PLL: begin
                nxt_first  = pll_out;
                nxt_second = diff && !pll_out;
            end
            AWG_GRP_DUTY: begin
                nxt_first  = carry;
                nxt_second = diff && !carry;
            end
            default: begin
                nxt_first  = 1'b0;
                nxt_second = 1'b0;
            end
        endcase
    end

    // pin flops; the direction bits only gate the enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_ff  <= 1'b0;
            second_ff <= 1'b0;
        end else begin
            first_ff  <= nxt_first;
            second_ff <= nxt_second;
        end
    end

    assign first_pin     = first_ff;
    assign second_pin    = second_ff;
    assign first_pin_oe  = dir_ff[0];
    assign second_pin_oe = dir_ff[1];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // writes land at the strobe edge and show one cycle later
    a_acc_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == AWG_ACC_OFS |=> acc == $past(reg_wdata))
        else $error("accumulator load lost");

    a_incr_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == AWG_INCR_OFS |=> incr_ff == $past(reg_wdata))
        else $error("increment write lost");

    a_dir_enables: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == AWG_DIR_OFS
        |=> {second_pin_oe, first_pin_oe} == $past(reg_wdata[1:0]))
        else $error("direction bits not on enables");

    a_ctrl_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == AWG_CTRL_OFS
        |=> ctrl_ff == ($past(reg_wdata) & AWG_CTRL_MASK))
        else $error("control write not masked");

    // read data stands for the one cycle after the strobe, zero otherwise
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    a_rdata_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == AWG_CTRL_OFS |=> reg_rdata == $past(ctrl_ff))
        else $error("control read wrong");

    a_rdata_incr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == AWG_INCR_OFS |=> reg_rdata == $past(incr_ff))
        else $error("increment read wrong");

    a_rdata_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == AWG_ACC_OFS |=> reg_rdata == $past(acc))
        else $error("accumulator read wrong");

    // oscillator modes: pins follow the msb one cycle late
    a_nco_msb_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_NCO && $stable(ctrl_ff) |=> first_pin == $past(acc[31]))
        else $error("oscillator pin not msb");

    a_nco_diff_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        counter_mode_select == AWG_MODE_NCO_DF && $stable(ctrl_ff)
        |=> second_pin == !first_pin)
        else $error("differential pin not inverted");

    a_se_second_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !diff |=> !second_pin)
        else $error("single-ended second pin active");

    a_half_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_NCO && incr_ff == 32'h8000_0000 && !reg_wr
        |=> acc[31] != $past(acc[31]))
        else $error("half scale msb did not toggle");

    a_quarter_seq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_NCO && incr_ff == 32'h4000_0000 && acc == 32'h0000_0000
        && !reg_wr ##1 !reg_wr ##1 !reg_wr |=> acc[31] ##1 !acc[31])
        else $error("quarter sequence broken");

    a_quarter_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_NCO && incr_ff == 32'h4000_0000 && acc == 32'h0000_0000
        && !reg_wr ##1 !reg_wr ##1 !reg_wr
        |-> acc[31] && !$past(acc[31]) && !$past(acc[31], 2))
        else $error("quarter increment msb pattern wrong");

    // above half scale the phase steps backwards, so the rate falls again
    a_fold_quarter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_NCO && incr_ff == 32'hc000_0000 && !reg_wr
        |=> acc[31:30] == 2'($past(acc[31:30]) - 2'h1))
        else $error("three quarter step not folded");

    // pll modes: tap output on the first pin, inverse on the second when differential
    a_pll_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_PLL && $stable(ctrl_ff) |=> first_pin == $past(pll_out))
        else $error("pll pin not tap output");

    a_pll_diff: assert property (@(posedge clk_sys) disable iff (!rst_n)
        counter_mode_select == AWG_MODE_PLL_DF |=> second_pin == !first_pin)
        else $error("pll differential not inverted");

    a_pll_tap_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp != AWG_GRP_PLL |=> !pll_out)
        else $error("pll output active outside pll modes");

    // duty modes: the add carry drives the first pin
    a_duty_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_DUTY && $stable(ctrl_ff) |=> first_pin == $past(carry))
        else $error("duty pin not carry");

    a_duty_diff: assert property (@(posedge clk_sys) disable iff (!rst_n)
        counter_mode_select == AWG_MODE_DUTY_DF && $stable(ctrl_ff)
        |=> second_pin == !first_pin)
        else $error("differential duty not inverted");

    a_one_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_DUTY && incr_ff == 32'h0000_0001 && !reg_wr
        |=> carry == ($past(acc) == 32'hffff_ffff))
        else $error("unit increment carry wrong");

    a_ones_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_DUTY && incr_ff == 32'hffff_ffff && !reg_wr
        |=> carry == ($past(acc) != 32'h0000_0000))
        else $error("all-ones increment carry wrong");

    a_half_equal: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_DUTY && incr_ff == 32'h8000_0000 && !reg_wr
        && $stable(incr_ff) && $stable(ctrl_ff) |=> carry == !acc[31])
        else $error("half scale duty differs from oscillator");

    // off and video codes: accumulator frozen, pins low
    a_off_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_OFF && $stable(ctrl_ff) |=> !first_pin && !second_pin)
        else $error("pins active in off mode");

    a_off_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grp == AWG_GRP_OFF && !reg_wr |=> acc == $past(acc))
        else $error("accumulator moved while off");

endmodule : awg_top

// ### tb.sv
// testbench: register tasks and waveform checks for the generator
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import awg_pkg::*;
;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic        clk_sys   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        first_pin, first_pin_oe, second_pin, second_pin_oe;
    logic        pad_a, pad_b;
    int          n_fail       = 0;
    int          total_checks = 0;
    int          hi, rs, rs0, k;
    logic [31:0] ftab [5] = '{32'h8000_0000, 32'h4000_0000, 32'hc000_0000,
                              32'h3000_0000, 32'h0100_0000};
    int          fexp [5] = '{512, 256, 256, 192, 4};
    logic [31:0] dtab [4] = '{32'h4000_0000, 32'h8000_0000, 32'hffff_ffff, 32'h2000_0001};
    int          dexp [4] = '{256, 512, 1023, 128};
    logic [6:0]  pat      = 7'h4c;

    // 8 ns system clock
    always #4 clk_sys = ~clk_sys;

    awg_top u_awg_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_pin(first_pin),
        .first_pin_oe(first_pin_oe), .second_pin(second_pin), .second_pin_oe(second_pin_oe)
    );
    awg_pin_load u_awg_pin_load (
        .first_pin(first_pin), .first_pin_oe(first_pin_oe), .second_pin(second_pin),
        .second_pin_oe(second_pin_oe), .pad_a(pad_a), .pad_b(pad_b)
    );

    // --------------------------------------------------------------
    // bus tasks
    // --------------------------------------------------------------
    // strobes drop on the following edge, so calls never clash in one step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, exp)
    endtask : rd_chk

    // stop first so every run starts from a frozen accumulator and quiet pins
    task automatic cfg(input logic [4:0] m, input logic [2:0] t, input logic [31:0] inc,
                       input logic [31:0] a);
        wr_reg(AWG_CTRL_OFS, 32'h0000_0000);
        wr_reg(AWG_INCR_OFS, inc);
        wr_reg(AWG_ACC_OFS, a);
        wr_reg(AWG_CTRL_OFS, {1'b0, m, t, 23'h00_0000});
    endtask : cfg

    // counts high cycles and rising edges on the first pad
    task automatic measure(input int n, input bit diff, output int highs, output int rises);
        logic prev;
        prev  = pad_a;
        highs = 0;
        rises = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
            if (pad_a === 1'b1) highs++;
            if (pad_a === 1'b1 && prev === 1'b0) rises++;
            if (diff) `CHK(pad_b, ~pad_a) else `CHK(pad_b, 1'b0)
            prev = pad_a;
        end
    endtask : measure

    function automatic bit near(input int g, input int e, input int tol);
        return (g >= e - tol) && (g <= e + tol);
    endfunction : near

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values, read-only ctrl bits, unmapped place
        rd_chk(AWG_CTRL_OFS, AWG_RST_VAL);
        rd_chk(AWG_INCR_OFS, 32'h0000_0000);
        rd_chk(AWG_ACC_OFS, 32'h0000_0000);
        rd_chk(AWG_DIR_OFS, 32'h0000_0000);
        wr_reg(AWG_CTRL_OFS, 32'hffff_ffff);
        rd_chk(AWG_CTRL_OFS, AWG_CTRL_MASK);
        wr_reg(8'h10, 32'hdead_beef);
        rd_chk(8'h10, 32'h0000_0000);
        $display("test registers done");
        // pads stay quiet until direction is set
        cfg(AWG_MODE_NCO_SE, 3'h0, 32'h8000_0000, 32'h0000_0000);
        measure(64, 1'b0, hi, rs);
        `CHK(hi, 0)
        wr_reg(AWG_DIR_OFS, 32'h0000_0003);
        rd_chk(AWG_DIR_OFS, 32'h0000_0003);
        measure(64, 1'b0, hi, rs);
        `CHK(hi, 32)
        $display("test direction done");
        // quarter step: msb pattern 1,1,0,0 from the first high
        cfg(AWG_MODE_NCO_DF, 3'h0, 32'h4000_0000, 32'h0000_0000);
        k = 0;
        do begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (pad_a !== 1'b1 && k < 64);
        if (k >= 64) begin
            n_fail++;
            report_and_stop();
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys);
            #1;
            `CHK(pad_a, pat[6-i])
            `CHK(pad_b, ~pad_a)
        end
        $display("test quarter done");
        // oscillator frequency, fold above half scale, uneven steps, tap ignored
        for (int i = 0; i < 5; i++) begin
            cfg(AWG_MODE_NCO_SE, 3'h7, ftab[i], 32'h0000_0000);
            measure(1024, 1'b0, hi, rs);
            `CHK(near(rs, fexp[i], 1), 1'b1)
        end
        $display("test frequency done");
        // software pwm: increment one, negated width loaded
        cfg(AWG_MODE_NCO_SE, 3'h0, 32'h0000_0001, 32'hffff_ffec);
        measure(40, 1'b0, hi, rs);
        `CHK(hi, 20)
        $display("test pwm done");
        // duty fraction, one value per update period as a dac would
        for (int i = 0; i < 4; i++) begin
            cfg(AWG_MODE_DUTY_DF, 3'h7, dtab[i], 32'h0000_0000);
            measure(1024, 1'b1, hi, rs);
            `CHK(near(hi, dexp[i], 1), 1'b1)
            if (i == 1) `CHK(near(rs, 512, 1), 1'b1)
        end
        cfg(AWG_MODE_DUTY_SE, 3'h0, 32'h0000_0001, 32'hffff_fff0);
        measure(40, 1'b0, hi, rs);
        `CHK(hi, 1)
        $display("test duty done");
        // video code is off here: frozen accumulator, quiet pins
        cfg(AWG_MODE_VIDEO, 3'h7, 32'h4000_0000, 32'h1234_5678);
        measure(64, 1'b0, hi, rs);
        `CHK(hi, 0)
        rd_chk(AWG_ACC_OFS, 32'h1234_5678);
        $display("test off done");
        // pll at a 6.25 MHz reference: slowest tap far below tap three
        cfg(AWG_MODE_PLL_DF, 3'h0, 32'h0ccc_cccd, 32'h0000_0000);
        measure(256, 1'b1, hi, rs0);
        measure(2000, 1'b1, hi, rs0);
        `CHK(near(rs0, 13, 12), 1'b1)
        cfg(AWG_MODE_PLL_SE, 3'h3, 32'h0ccc_cccd, 32'h0000_0000);
        measure(256, 1'b0, hi, rs);
        measure(2000, 1'b0, hi, rs);
        `CHK(rs > 3 * rs0, 1'b1)
        $display("test pll done");
        report_and_stop();
    end

    // watchdog against a hang anywhere in the sequence
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
endmodule : tb
